// [core/msb_unit.sv]
// emulator-side end of the measurement sync bus with apb configuration
`timescale 1ns/1ps
`include "msb_defs.svh"
module msb_unit (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [31:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  msb_if.unit                      bus,
  input  wire logic                core_break_req,
  input  wire logic                core_ready,
  input  wire logic                core_in_reset,
  input  wire logic                ana_trig_found,
  output logic                     emu_break,
  output logic                     run_start,
  output logic                     run_use_addr,
  output logic      [31:0]         run_addr,
  output logic                     trace_restart,
  output logic                     ana_arm,
  output logic                     ana_trig_in,
  output logic                     itl_one,
  output logic                     itl_two
);
  import msb_pkg::*;

  logic [31:0] ctrl_reg, ctrl_next;
  msb_route_t  route_reg, route_next;
  logic [31:0] start_reg, start_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [3:0]  sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic        go_prev_reg, go_prev_next, bnc_prev_reg, bnc_prev_next;
  logic [3:0]  mask_reg, mask_next, go_cnt_reg, go_cnt_next, bnc_cnt_reg, bnc_cnt_next;
  msb_state_t  state_reg, state_next;
  logic        pend_reg, pend_next;
  logic        itl1_reg, itl1_next, itl2_reg, itl2_next;
  logic        arm_reg, arm_next, trin_reg, trin_next;
  logic        run_reg, run_next, use_reg, use_next, trace_reg, trace_next;
  logic        trig_oe_reg, trig_oe_next, ready_oe_reg, ready_oe_next;
  logic        bnc_oe_reg, bnc_oe_next;
  logic        own_pull_reg, own_pull_next;
  logic        wr, rd_setup, hit, part_en;
  logic        trig_act, ready_s, go_fall, bnc_hit, go_cmd, go_evt, brk_src;
  logic        trig_pulse, bnc_src;

  assign part_en       = ctrl_reg[`MSB_CTRL_PART];
  assign pready        = 1'b1;
  assign prdata        = prdata_reg;
  assign emu_break     = (state_reg == MSB_BRK);
  assign run_start     = run_reg;
  assign run_use_addr  = use_reg;
  assign run_addr      = start_reg;
  assign trace_restart = trace_reg;
  assign ana_arm       = arm_reg;
  assign ana_trig_in   = trin_reg;
  assign itl_one       = itl1_reg;
  assign itl_two       = itl2_reg;
  // open-drain style: output value fixed, enable does the pulling
  assign bus.unit_trig_n_o  = 1'b0;
  assign bus.unit_trig_n_oe = trig_oe_reg;
  assign bus.unit_ready_o   = 1'b0;
  assign bus.unit_ready_oe  = ready_oe_reg;
  assign bus.unit_go_n_o    = 1'b0;
  assign bus.unit_go_n_oe   = (go_cnt_reg != 4'h0);
  assign bus.unit_bnc_o     = 1'b1;
  assign bus.unit_bnc_oe    = bnc_oe_reg;

  always_comb begin
    hit = (paddr[7:0] == `MSB_OFF_CTRL) || (paddr[7:0] == `MSB_OFF_ROUTE) ||
          (paddr[7:0] == `MSB_OFF_START) || (paddr[7:0] == `MSB_OFF_CMD) ||
          (paddr[7:0] == `MSB_OFF_STATUS);
    hit = hit && (paddr[31:8] == 24'h00_0000);
    wr       = psel && penable && pwrite && hit;
    rd_setup = psel && !penable && !pwrite;
    pslverr  = psel && penable && !hit;
    ctrl_next  = ctrl_reg;
    route_next = route_reg;
    start_next = start_reg;
    go_cmd     = 1'b0;
    bnc_prev_next = sync2_reg[0];
    if (wr && paddr[7:0] == `MSB_OFF_CTRL) begin
      ctrl_next = {29'h0, pwdata[2:0]};
    end else if (wr && paddr[7:0] == `MSB_OFF_ROUTE) begin
      route_next    = msb_route_t'({14'h0000, pwdata[17:0]});
      bnc_prev_next = 1'b1;
    end else if (wr && paddr[7:0] == `MSB_OFF_START) begin
      start_next = pwdata;
    end else if (wr && paddr[7:0] == `MSB_OFF_CMD) begin
      go_cmd = pwdata[`MSB_CMD_GO];
    end
    prdata_next = prdata_reg;
    if (rd_setup) begin
      if (paddr[7:0] == `MSB_OFF_CTRL) begin
        prdata_next = ctrl_reg;
      end else if (paddr[7:0] == `MSB_OFF_ROUTE) begin
        prdata_next = route_reg;
      end else if (paddr[7:0] == `MSB_OFF_START) begin
        prdata_next = start_reg;
      end else if (paddr[7:0] == `MSB_OFF_STATUS) begin
        prdata_next = {25'h0, pend_reg, itl2_reg, itl1_reg, sync2_reg[1], ~sync2_reg[3],
                       sync2_reg[2], emu_break};
      end else begin
        prdata_next = 32'h0000_0000;
      end
    end

    // first stage feeds only the second stage
    sync1_next = {bus.trig_n, bus.ready, bus.go_n, bus.bnc};
    sync2_next = sync1_reg;
    go_prev_next = sync2_reg[1];
    // own go and trigger echo are blanked while the mask runs
    trig_act = !sync2_reg[3] && (mask_reg == 4'h0);
    // own pull takes two edges to come back; a stale high would restart early
    ready_s  = sync2_reg[2] && !ready_oe_reg && !own_pull_reg;
    own_pull_next = ready_oe_reg;
    go_fall  = !sync2_reg[1] && go_prev_reg && (mask_reg == 4'h0);
    bnc_hit  = sync2_reg[0] && !bnc_prev_reg;
    go_evt   = go_cmd || go_fall;
    trace_next = go_evt && ctrl_reg[`MSB_CTRL_TRACE];
    mask_next  = go_evt ? 4'(`MSB_MASK_CYC) : ((mask_reg != 4'h0) ? mask_reg - 4'h1 : 4'h0);
    go_cnt_next = go_cmd ? 4'(`MSB_GO_CYC) : ((go_cnt_reg != 4'h0) ? go_cnt_reg - 4'h1 : 4'h0);
    trig_pulse = mask_reg > 4'(`MSB_MASK_CYC - `MSB_TRIG_CYC);

    // a line both driving and receiving the same internal line would latch up
    itl1_next = (route_reg.tgout_sel == MSB_SEL_ONE && ana_trig_found) ||
                (route_reg.cmb_rx_one && !route_reg.cmb_drv_one && trig_act) ||
                (route_reg.bnc_rx_one && !route_reg.bnc_drv_one && bnc_hit);
    itl2_next = (route_reg.tgout_sel == MSB_SEL_TWO && ana_trig_found) ||
                (route_reg.cmb_rx_two && !route_reg.cmb_drv_two && trig_act) ||
                (route_reg.bnc_rx_two && !route_reg.bnc_drv_two && bnc_hit);
    arm_next  = (route_reg.arm_sel == MSB_SEL_ONE && itl1_reg) ||
                (route_reg.arm_sel == MSB_SEL_TWO && itl2_reg);
    trin_next = (route_reg.trig_in_sel == MSB_SEL_ONE && itl1_reg) ||
                (route_reg.trig_in_sel == MSB_SEL_TWO && itl2_reg);
    trig_oe_next = (route_reg.cmb_drv_one && itl1_reg) ||
                   (route_reg.cmb_drv_two && itl2_reg) || trig_pulse;
    bnc_src = (route_reg.bnc_drv_one && itl1_reg) || (route_reg.bnc_drv_two && itl2_reg);
    // stretch so a one-cycle internal pulse still meets the far receiver's width
    bnc_cnt_next = bnc_src ? 4'(`MSB_BNC_MIN_CYC) :
                   ((bnc_cnt_reg != 4'h0) ? bnc_cnt_reg - 4'h1 : 4'h0);
    bnc_oe_next  = bnc_src || (bnc_cnt_reg > 4'h1);

    brk_src = (route_reg.brk_one && itl1_reg) || (route_reg.brk_two && itl2_reg) ||
              (route_reg.cmb_brk && trig_act) || (route_reg.bnc_brk && bnc_hit) ||
              core_break_req;
    state_next = state_reg;
    pend_next  = pend_reg || (go_evt && part_en);
    run_next   = 1'b0;
    use_next   = use_reg;
    case (state_reg)
      MSB_RUN: begin
        if (brk_src || core_in_reset || (part_en && (!ready_s || go_evt))) begin
          state_next = MSB_BRK;
        end
      end
      MSB_BRK: begin
        // a level break source still asserted keeps the unit halted
        if (core_ready && !core_in_reset && !brk_src && !go_evt &&
            (!part_en || ready_s)) begin
          state_next = MSB_RUN;
          run_next   = 1'b1;
          use_next   = pend_reg && ctrl_reg[`MSB_CTRL_START_OK];
          pend_next  = 1'b0;
        end
      end
      default: state_next = MSB_RUN;
    endcase
    ready_oe_next = part_en && (core_in_reset ||
                    (state_reg == MSB_BRK && !core_ready) ||
                    (state_reg == MSB_RUN && (brk_src || go_evt)));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= `MSB_CTRL_RESET;
      route_reg    <= msb_route_t'(`MSB_ROUTE_RESET);
      start_reg    <= 32'h0000_0000;
      prdata_reg   <= 32'h0000_0000;
      sync1_reg    <= 4'hF;
      sync2_reg    <= 4'hF;
      go_prev_reg  <= 1'b1;
      bnc_prev_reg <= 1'b1;
      mask_reg     <= 4'h0;
      go_cnt_reg   <= 4'h0;
      bnc_cnt_reg  <= 4'h0;
      state_reg    <= MSB_BRK;
      pend_reg     <= 1'b0;
      itl1_reg     <= 1'b0;
      itl2_reg     <= 1'b0;
      arm_reg      <= 1'b0;
      trin_reg     <= 1'b0;
      run_reg      <= 1'b0;
      use_reg      <= 1'b0;
      trace_reg    <= 1'b0;
      trig_oe_reg  <= 1'b0;
      ready_oe_reg <= 1'b0;
      bnc_oe_reg   <= 1'b0;
      own_pull_reg <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      route_reg    <= route_next;
      start_reg    <= start_next;
      prdata_reg   <= prdata_next;
      sync1_reg    <= sync1_next;
      sync2_reg    <= sync2_next;
      go_prev_reg  <= go_prev_next;
      bnc_prev_reg <= bnc_prev_next;
      mask_reg     <= mask_next;
      go_cnt_reg   <= go_cnt_next;
      bnc_cnt_reg  <= bnc_cnt_next;
      state_reg    <= state_next;
      pend_reg     <= pend_next;
      itl1_reg     <= itl1_next;
      itl2_reg     <= itl2_next;
      arm_reg      <= arm_next;
      trin_reg     <= trin_next;
      run_reg      <= run_next;
      use_reg      <= use_next;
      trace_reg    <= trace_next;
      trig_oe_reg  <= trig_oe_next;
      ready_oe_reg <= ready_oe_next;
      bnc_oe_reg   <= bnc_oe_next;
      own_pull_reg <= own_pull_next;
    end
  end
endmodule : msb_unit

// [core/msb_defs.svh]
// offsets, field positions and timing counts for the measurement sync bus
`ifndef MSB_DEFS_SVH
`define MSB_DEFS_SVH
`define MSB_OFF_CTRL        8'h00
`define MSB_OFF_ROUTE       8'h04
`define MSB_OFF_START       8'h08
`define MSB_OFF_CMD         8'h0C
`define MSB_OFF_STATUS      8'h10
`define MSB_CTRL_PART       0
`define MSB_CTRL_TRACE      1
`define MSB_CTRL_START_OK   2
`define MSB_CTRL_RESET      32'h0000_0000
`define MSB_ROUTE_RESET     32'h0000_0000
`define MSB_CMD_GO          0
`define MSB_CLK_PS          8000
`define MSB_BNC_MIN_NS      25
`define MSB_BNC_MIN_CYC     ((`MSB_BNC_MIN_NS * 1000 + `MSB_CLK_PS - 1) / `MSB_CLK_PS)
`define MSB_TRIG_CYC        4
`define MSB_GO_CYC          4
`define MSB_MASK_CYC        (`MSB_TRIG_CYC + `MSB_GO_CYC + 3)
`endif

// [core/msb_pkg.sv]
// types shared by both ends of the measurement sync bus
package msb_pkg;
  typedef enum logic {MSB_RUN, MSB_BRK} msb_state_t;
  typedef enum logic [1:0] {MSB_SEL_NONE, MSB_SEL_ONE, MSB_SEL_TWO, MSB_SEL_RSVD} msb_sel_t;
  typedef struct packed {
    logic [13:0] unused;
    msb_sel_t    trig_in_sel;
    logic        bnc_brk;
    logic        cmb_brk;
    logic        brk_two;
    logic        brk_one;
    msb_sel_t    arm_sel;
    msb_sel_t    tgout_sel;
    logic        bnc_rx_two;
    logic        bnc_rx_one;
    logic        bnc_drv_two;
    logic        bnc_drv_one;
    logic        cmb_rx_two;
    logic        cmb_rx_one;
    logic        cmb_drv_two;
    logic        cmb_drv_one;
  } msb_route_t;
endpackage : msb_pkg

// [core/msb_if.sv]
// shared bus lines: trigger, ready and go wires plus the coaxial trigger
`timescale 1ns/1ps
interface msb_if;
  logic unit_trig_n_o, unit_trig_n_oe, peer_trig_n_o, peer_trig_n_oe;
  logic unit_ready_o,  unit_ready_oe,  peer_ready_o,  peer_ready_oe;
  logic unit_go_n_o,   unit_go_n_oe,   peer_go_n_o,   peer_go_n_oe;
  logic unit_bnc_o,    unit_bnc_oe,    peer_bnc_o,    peer_bnc_oe;
  logic trig_n;
  logic ready;
  logic go_n;
  logic bnc;
  // pulled-up wired lines: any enabled driver pulls low; coax is wired-or high
  assign trig_n = !((unit_trig_n_oe && !unit_trig_n_o) || (peer_trig_n_oe && !peer_trig_n_o));
  assign ready  = !((unit_ready_oe && !unit_ready_o) || (peer_ready_oe && !peer_ready_o));
  assign go_n   = !((unit_go_n_oe && !unit_go_n_o) || (peer_go_n_oe && !peer_go_n_o));
  assign bnc    = (unit_bnc_oe && unit_bnc_o) || (peer_bnc_oe && peer_bnc_o);
  modport unit (input trig_n, ready, go_n, bnc,
                output unit_trig_n_o, unit_trig_n_oe, unit_ready_o, unit_ready_oe,
                output unit_go_n_o, unit_go_n_oe, unit_bnc_o, unit_bnc_oe);
  modport peer (input trig_n, ready, go_n, bnc,
                output peer_trig_n_o, peer_trig_n_oe, peer_ready_o, peer_ready_oe,
                output peer_go_n_o, peer_go_n_oe, peer_bnc_o, peer_bnc_oe);
endinterface : msb_if

// [core/msb_peer.sv]
// far-side party on the measurement sync bus: a peer or external instrument
`timescale 1ns/1ps
`include "msb_defs.svh"
module msb_peer (
  input  wire logic  pclk,
  input  wire logic  presetn,
  msb_if.peer        bus,
  input  wire logic  go_req,
  input  wire logic  hold_not_ready,
  input  wire logic  trig_drive,
  input  wire logic  bnc_fire,
  output logic       ready_seen,
  output logic       trig_seen,
  output logic       go_seen,
  output logic       bnc_seen
);
  import msb_pkg::*;

  logic [3:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic       go_prev_reg, go_prev_next, bnc_prev_reg, bnc_prev_next;
  logic [3:0] go_cnt_reg, go_cnt_next, bnc_cnt_reg, bnc_cnt_next;
  logic       go_seen_reg, go_seen_next, bnc_seen_reg, bnc_seen_next;
  logic       trig_oe_reg, trig_oe_next, ready_oe_reg, ready_oe_next;

  assign ready_seen = sync2_reg[2];
  assign trig_seen  = !sync2_reg[3];
  assign go_seen    = go_seen_reg;
  assign bnc_seen   = bnc_seen_reg;
  assign bus.peer_trig_n_o  = 1'b0;
  assign bus.peer_trig_n_oe = trig_oe_reg;
  assign bus.peer_ready_o   = 1'b0;
  assign bus.peer_ready_oe  = ready_oe_reg;
  assign bus.peer_go_n_o    = 1'b0;
  assign bus.peer_go_n_oe   = (go_cnt_reg != 4'h0);
  assign bus.peer_bnc_o     = 1'b1;
  assign bus.peer_bnc_oe    = (bnc_cnt_reg != 4'h0);

  always_comb begin
    sync1_next    = {bus.trig_n, bus.ready, bus.go_n, bus.bnc};
    sync2_next    = sync1_reg;
    go_prev_next  = sync2_reg[1];
    bnc_prev_next = sync2_reg[0];
    go_seen_next  = !sync2_reg[1] && go_prev_reg;
    bnc_seen_next = sync2_reg[0] && !bnc_prev_reg;
    // caller must drop trig_drive before expecting the unit to resume
    trig_oe_next  = trig_drive;
    ready_oe_next = hold_not_ready;
    go_cnt_next   = go_req ? 4'(`MSB_GO_CYC) :
                    ((go_cnt_reg != 4'h0) ? go_cnt_reg - 4'h1 : 4'h0);
    bnc_cnt_next  = bnc_fire ? 4'(`MSB_BNC_MIN_CYC) :
                    ((bnc_cnt_reg != 4'h0) ? bnc_cnt_reg - 4'h1 : 4'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg    <= 4'hF;
      sync2_reg    <= 4'hF;
      go_prev_reg  <= 1'b1;
      bnc_prev_reg <= 1'b1;
      go_cnt_reg   <= 4'h0;
      bnc_cnt_reg  <= 4'h0;
      go_seen_reg  <= 1'b0;
      bnc_seen_reg <= 1'b0;
      trig_oe_reg  <= 1'b0;
      ready_oe_reg <= 1'b0;
    end else begin
      sync1_reg    <= sync1_next;
      sync2_reg    <= sync2_next;
      go_prev_reg  <= go_prev_next;
      bnc_prev_reg <= bnc_prev_next;
      go_cnt_reg   <= go_cnt_next;
      bnc_cnt_reg  <= bnc_cnt_next;
      go_seen_reg  <= go_seen_next;
      bnc_seen_reg <= bnc_seen_next;
      trig_oe_reg  <= trig_oe_next;
      ready_oe_reg <= ready_oe_next;
    end
  end
endmodule : msb_peer

// [test/msb_properties.sv]
// concurrent checks on the shared lines between the unit and the peer
`timescale 1ns/1ps
module msb_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic unit_trig_n_o,
  input wire logic unit_trig_n_oe,
  input wire logic unit_ready_o,
  input wire logic unit_ready_oe,
  input wire logic unit_go_n_o,
  input wire logic unit_go_n_oe,
  input wire logic unit_bnc_o,
  input wire logic unit_bnc_oe,
  input wire logic peer_go_n_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // go drive is a fixed four-cycle low pulse, then released
  sequence go_pulse_s;
    unit_go_n_oe [*4] ##1 !unit_go_n_oe;
  endsequence
  sequence trig_echo_s;
    ##1 unit_trig_n_oe [*4];
  endsequence
  chk_trig_low_true: assert property (unit_trig_n_o == 1'b0)
    else $error("trigger drive level is not low");
  chk_ready_open_drain: assert property (unit_ready_o == 1'b0)
    else $error("ready is driven high instead of released");
  chk_go_low_true: assert property (unit_go_n_o == 1'b0)
    else $error("go drive level is not low");
  chk_coax_high_true: assert property (unit_bnc_o == 1'b1)
    else $error("coax drive level is not high");
  chk_go_pulse_len: assert property ($rose(unit_go_n_oe) |-> go_pulse_s)
    else $error("go pulse length wrong");
  chk_own_go_echo: assert property ($rose(unit_go_n_oe) |-> trig_echo_s)
    else $error("no trigger pulse after own go");
  chk_peer_go_echo: assert property (
    $rose(peer_go_n_oe) && !unit_go_n_oe |-> ##[2:6] unit_trig_n_oe)
    else $error("no trigger pulse after received go");
  chk_coax_min_width: assert property ($rose(unit_bnc_oe) |-> unit_bnc_oe [*4])
    else $error("coax pulse shorter than four cycles");
  chk_quiet_after_reset: assert property (
    $rose(presetn) |-> !unit_ready_oe && !unit_go_n_oe && !unit_trig_n_oe && !unit_bnc_oe)
    else $error("line driven right after reset");
endmodule : msb_properties

// [test/measurement_sync_bus_tb.sv]
// self-checking bench joining the unit and the peer over the shared lines
`timescale 1ns/1ps
`include "msb_defs.svh"
module measurement_sync_bus_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, run_addr, ra;
  logic        core_break_req, core_ready, core_in_reset, hold_not_ready, trig_drive;
  logic        emu_break, run_start, run_use_addr, trace_restart, ana_arm, itl_one, itl_two;
  logic        ready_seen, trig_seen, go_seen, bnc_seen, ru, ana_trig_in;
  logic [2:0]  pls;
  logic [10:0] obs, seen;
  int          failures = 0, cmp_count = 0, cycles = 0;
  msb_if bus_if ();
  msb_unit msb_unit_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus_if.unit), .core_break_req(core_break_req),
    .core_ready(core_ready), .core_in_reset(core_in_reset), .ana_trig_found(pls[2]),
    .emu_break(emu_break), .run_start(run_start), .run_use_addr(run_use_addr),
    .run_addr(run_addr), .trace_restart(trace_restart), .ana_arm(ana_arm),
    .ana_trig_in(ana_trig_in),
    .itl_one(itl_one), .itl_two(itl_two));
  msb_peer msb_peer_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if.peer), .go_req(pls[0]),
    .hold_not_ready(hold_not_ready), .trig_drive(trig_drive), .bnc_fire(pls[1]),
    .ready_seen(ready_seen), .trig_seen(trig_seen), .go_seen(go_seen), .bnc_seen(bnc_seen));
  msb_properties msb_properties_inst (.pclk(pclk), .presetn(presetn),
    .unit_trig_n_o(bus_if.unit_trig_n_o), .unit_trig_n_oe(bus_if.unit_trig_n_oe),
    .unit_ready_o(bus_if.unit_ready_o), .unit_ready_oe(bus_if.unit_ready_oe),
    .unit_go_n_o(bus_if.unit_go_n_o), .unit_go_n_oe(bus_if.unit_go_n_oe),
    .unit_bnc_o(bus_if.unit_bnc_o), .unit_bnc_oe(bus_if.unit_bnc_oe),
    .peer_go_n_oe(bus_if.peer_go_n_oe));
  assign obs = {ana_trig_in, bnc_seen, ready_seen, trig_seen, go_seen, ana_arm, itl_two, itl_one,
                trace_restart, run_start, emu_break};
  // sticky record, so single-cycle pulses are not lost between waits
  always @(negedge pclk) begin
    seen <= seen | obs;
    if (run_start === 1'b1) begin
      ru <= run_use_addr;
      ra <= run_addr;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] off, input logic [31:0] wd,
                     output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h00_0000, off};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, off, d, q, e);
  endtask : wr
  task automatic rdchk(input logic [7:0] off, input logic [31:0] exp, input logic xe,
                       input string name);
    logic [31:0] q;
    logic        e;
    apb(1'b0, off, 32'h0000_0000, q, e);
    check(name, exp, q);
    check(name, {31'h0, xe}, {31'h0, e});
  endtask : rdchk
  task automatic clr();
    @(posedge pclk);
    seen <= '0;
  endtask : clr
  task automatic pulse(input logic [2:0] m);
    @(posedge pclk);
    pls <= m;
    @(posedge pclk);
    pls <= 3'b000;
  endtask : pulse
  // bounded wait: a rise is taken from the sticky record, a fall from the live value
  task automatic wait_sig(input int idx, input logic val, input string name);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (((val === 1'b1) ? seen[idx] : obs[idx]) !== val && n < 80);
    check(name, {31'h0, val}, {31'h0, (val === 1'b1) ? seen[idx] : obs[idx]});
    @(posedge pclk);
  endtask : wait_sig
  task automatic quiet(input int idx, input string name);
    repeat (20) @(negedge pclk);
    check(name, 32'h0, {31'h0, seen[idx]});
    @(posedge pclk);
  endtask : quiet
  task automatic s_regs();
    rdchk(`MSB_OFF_CTRL, `MSB_CTRL_RESET, 1'b0, "ctrl reset");
    rdchk(`MSB_OFF_ROUTE, `MSB_ROUTE_RESET, 1'b0, "route reset");
    wr(`MSB_OFF_START, 32'h1234_5678);
    rdchk(`MSB_OFF_START, 32'h1234_5678, 1'b0, "start addr");
    rdchk(`MSB_OFF_CMD, 32'h0000_0000, 1'b0, "cmd read");
    rdchk(`MSB_OFF_STATUS, 32'h0000_000A, 1'b0, "status idle");
    rdchk(8'h40, 32'h0000_0000, 1'b1, "unmapped");
  endtask : s_regs
  task automatic s_go();
    wr(`MSB_OFF_ROUTE, 32'h0000_0004);
    wr(`MSB_OFF_CTRL, 32'h0000_0007);
    clr();
    wr(`MSB_OFF_CMD, 32'h0000_0001);
    wait_sig(2, 1'b1, "trace restart");
    wait_sig(6, 1'b1, "peer go");
    wait_sig(7, 1'b1, "peer trigger");
    wait_sig(1, 1'b1, "run start");
    check("run from addr", 32'h1, {31'h0, ru});
    check("run addr", 32'h1234_5678, ra);
    quiet(3, "echo ignored");
    wr(`MSB_OFF_CTRL, 32'h0000_0003);
    clr();
    pulse(3'b001);
    wait_sig(0, 1'b1, "go break");
    wait_sig(2, 1'b1, "trace on rx go");
    wait_sig(1, 1'b1, "run after go");
    check("run from pc", 32'h0, {31'h0, ru});
  endtask : s_go
  task automatic s_ready();
    wr(`MSB_OFF_CTRL, 32'h0000_0001);
    hold_not_ready <= 1'b1;
    wait_sig(0, 1'b1, "break on ready low");
    clr();
    quiet(1, "held while not ready");
    hold_not_ready <= 1'b0;
    wait_sig(1, 1'b1, "resume on ready");
    core_break_req <= 1'b1;
    core_ready <= 1'b0;
    wait_sig(8, 1'b0, "break pulls ready");
    clr();
    quiet(8, "ready kept low");
    core_break_req <= 1'b0;
    core_ready <= 1'b1;
    wait_sig(8, 1'b1, "ready released");
    wait_sig(1, 1'b1, "local resume");
    core_in_reset <= 1'b1;
    wait_sig(8, 1'b0, "reset pulls ready");
    wr(`MSB_OFF_CTRL, 32'h0000_0000);
    clr();
    wait_sig(8, 1'b1, "no participation");
    core_in_reset <= 1'b0;
  endtask : s_ready
  task automatic s_trig();
    wr(`MSB_OFF_ROUTE, 32'h0000_0004);
    trig_drive <= 1'b1;
    wait_sig(3, 1'b1, "bus trig rx");
    repeat (20) @(negedge pclk);
    check("bus trig level", 32'h1, {31'h0, itl_one});
    @(posedge pclk);
    trig_drive <= 1'b0;
    wait_sig(3, 1'b0, "bus trig drop");
    wr(`MSB_OFF_ROUTE, 32'h0000_1004);
    clr();
    trig_drive <= 1'b1;
    wait_sig(0, 1'b1, "trigger break");
    clr();
    quiet(1, "no resume while held");
    trig_drive <= 1'b0;
    wait_sig(1, 1'b1, "resume after trigger");
  endtask : s_trig
  task automatic s_coax();
    wr(`MSB_OFF_ROUTE, 32'h0000_0880);
    clr();
    pulse(3'b010);
    wait_sig(5, 1'b1, "coax arm");
    wr(`MSB_OFF_ROUTE, 32'h0000_8000);
    clr();
    pulse(3'b010);
    wait_sig(0, 1'b1, "coax break");
    wr(`MSB_OFF_ROUTE, 32'h0000_0110);
    clr();
    pulse(3'b100);
    wait_sig(9, 1'b1, "coax out");
    wr(`MSB_OFF_ROUTE, 32'h0000_0000);
    clr();
    pulse(3'b100);
    quiet(9, "coax unrouted");
    wr(`MSB_OFF_ROUTE, 32'h0001_0040);
    clr();
    pulse(3'b010);
    wait_sig(10, 1'b1, "coax to trig in");
  endtask : s_coax
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    core_break_req = 1'b0;
    core_ready = 1'b1;
    core_in_reset = 1'b0;
    hold_not_ready = 1'b0;
    trig_drive = 1'b0;
    pls = 3'b000;
    seen = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_go();
    s_ready();
    s_trig();
    s_coax();
    give_verdict();
  end
endmodule : measurement_sync_bus_tb
